// *** design/hub_pm_pkg.sv ***
package hub_pm_pkg;

    // Clock rates in MHz
    localparam int SYS_CLK_MHZ = 100;
    localparam int REF_CLK_MHZ = 66;

    // Processor reset release delay, counted in reference clocks
    localparam int RELEASE_REF_CYCLES = 65536;
    // Same delay in system clocks, rounded up as a least time
    localparam int RELEASE_SYS_CYCLES = (RELEASE_REF_CYCLES * SYS_CLK_MHZ + REF_CLK_MHZ - 1) / REF_CLK_MHZ;
    localparam int RELEASE_CNT_W = 17;

    // Helper counter width for checking the release delay
    localparam int RUN_CNT_W = 18;

    // Throttle duty cycle: a period of THROTTLE_SLOTS slots, each THROTTLE_SLOT_CYCLES clocks
    localparam int DUTY_W = 3;
    localparam int THROTTLE_SLOTS = 8;
    localparam int THROTTLE_SLOT_CYCLES = 16;
    localparam int SLOT_CNT_W = 4;

    // Reset values
    localparam logic RESET_OUT_ASSERTED = 1'b0;
    localparam logic STOP_CLOCK_IDLE = 1'b1;

    typedef enum logic {
        FULL_ON_ST,
        STOP_GRANT_ST
    } cpu_state_t;

    typedef struct packed {
        logic throttleEnable;
        logic [DUTY_W-1:0] throttleDuty;
        logic level2Read;
        logic stopGrantExit;
    } pm_ctrl_t;

    typedef struct packed {
        logic inStopGrant;
        logic throttling;
        logic resetReleased;
    } pm_status_t;

endpackage

// *** design/throttle_duty_gen.sv ***
`timescale 1ns/1ps
`default_nettype none

module throttle_duty_gen (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clear,
    input wire logic enable,
    input wire logic [hub_pm_pkg::DUTY_W-1:0] duty,
    output logic active
);
    import hub_pm_pkg::*;

    logic [SLOT_CNT_W-1:0] slotCount;
    logic [DUTY_W-1:0] phase;
    wire running = enable && !clear;
    wire slotEnd = (slotCount == SLOT_CNT_W'(THROTTLE_SLOT_CYCLES - 1));
    wire [DUTY_W-1:0] next_phase = slotEnd ? DUTY_W'(phase + 1'b1) : phase;
    wire next_active = running && (next_phase < duty);

    // Disabled or cleared throttling restarts at the start of a period
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slotCount <= '0;
            phase <= '0;
            active <= 1'b0;
        end else if (!running) begin
            slotCount <= '0;
            phase <= '0;
            active <= 1'b0;
        end else begin
            slotCount <= slotEnd ? '0 : SLOT_CNT_W'(slotCount + 1'b1);
            phase <= next_phase;
            active <= next_active;
        end
    end

    off_when_disabled_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !enable |=> !active)
        else $error("throttle active while disabled");

    zero_duty_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && !clear && duty == '0) |=> !active)
        else $error("throttle active at zero duty");

    duty_slot_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (enable && !clear && $past(enable) && $past(!clear) && slotCount == SLOT_CNT_W'(1)
            && phase < duty) |-> active)
        else $error("throttle idle inside its duty slots");

endmodule

`default_nettype wire

// *** design/hub_reset_and_cpu_stop_control.sv ***
`timescale 1ns/1ps
`default_nettype none

module hub_reset_and_cpu_stop_control #(
    parameter int RELEASE_CYCLES = hub_pm_pkg::RELEASE_SYS_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic platformResetInN,
    input wire hub_pm_pkg::pm_ctrl_t pmCtrl,
    output logic processorResetOutN,
    output logic stopClockRequestN,
    output hub_pm_pkg::pm_status_t pmStatus
);
    import hub_pm_pkg::*;

    cpu_state_t cpuState;
    cpu_state_t next_cpuState;
    logic [RELEASE_CNT_W-1:0] releaseCount;
    logic throttleActive;
    logic inReset;
    logic running;
    logic releaseDue;
    logic next_stopClock;

    // Platform reset acts as a synchronous reset for everything in the hub except pmStatus.resetReleased, which follows processorResetOutN a cycle later
    assign inReset = !platformResetInN;
    // Requests are taken only once the processor is out of reset
    assign running = platformResetInN && processorResetOutN;
    assign releaseDue = (releaseCount == RELEASE_CNT_W'(RELEASE_CYCLES - 1));

    // Stop-grant entry by level-2 read, left again on a break event
    always_comb begin
        next_cpuState = cpuState;
        case (cpuState)
            FULL_ON_ST: begin
                if (running && pmCtrl.level2Read) begin
                    next_cpuState = STOP_GRANT_ST;
                end
            end
            STOP_GRANT_ST: begin
                if (pmCtrl.stopGrantExit) begin
                    next_cpuState = FULL_ON_ST;
                end
            end
            default: begin
                next_cpuState = FULL_ON_ST;
            end
        endcase
        if (inReset) begin
            next_cpuState = FULL_ON_ST;
        end
    end

    // Stop-clock is asserted only for stop-grant or an active throttle slot
    assign next_stopClock = !inReset && ((next_cpuState == STOP_GRANT_ST)
        || (running && pmCtrl.throttleEnable && throttleActive));

    throttle_duty_gen dutyGen (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clear(!running),
        .enable(pmCtrl.throttleEnable),
        .duty(pmCtrl.throttleDuty),
        .active(throttleActive)
    );

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cpuState <= FULL_ON_ST;
            stopClockRequestN <= STOP_CLOCK_IDLE;
        end else begin
            cpuState <= next_cpuState;
            stopClockRequestN <= !next_stopClock;
        end
    end

    // Release counter restarts from zero on every platform reset assertion
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            releaseCount <= '0;
            processorResetOutN <= RESET_OUT_ASSERTED;
        end else if (inReset) begin
            releaseCount <= '0;
            processorResetOutN <= RESET_OUT_ASSERTED;
        end else if (!processorResetOutN) begin
            releaseCount <= RELEASE_CNT_W'(releaseCount + 1'b1);
            if (releaseDue) begin
                processorResetOutN <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pmStatus <= '0;
        end else begin
            pmStatus.inStopGrant <= (next_cpuState == STOP_GRANT_ST);
            pmStatus.throttling <= running && pmCtrl.throttleEnable && throttleActive;
            pmStatus.resetReleased <= processorResetOutN;
        end
    end

    // Cycles since platform reset last rose, saturating; read only by checks
    logic [RUN_CNT_W-1:0] highRun;
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            highRun <= '0;
        end else if (inReset) begin
            highRun <= '0;
        end else if (highRun != '1) begin
            highRun <= RUN_CNT_W'(highRun + 1'b1);
        end
    end

    sequence level2Taken_s;
        running && cpuState == FULL_ON_ST && pmCtrl.level2Read;
    endsequence

    sequence stopGrantHeld_s;
        cpuState == STOP_GRANT_ST && !stopClockRequestN;
    endsequence

    stop_grant_entry_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        level2Taken_s |=> stopGrantHeld_s)
        else $error("level-2 read did not enter stop-grant");

    no_throttle_off_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (running && !pmCtrl.throttleEnable && cpuState == FULL_ON_ST && !pmCtrl.level2Read)
            |=> stopClockRequestN)
        else $error("stop-clock asserted with throttling off");

    throttle_assert_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (running && pmCtrl.throttleEnable && throttleActive) |=> !stopClockRequestN)
        else $error("active throttle slot did not assert stop-clock");

    full_on_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!stopClockRequestN) |-> ($past(pmCtrl.throttleEnable) || cpuState == STOP_GRANT_ST))
        else $error("stop-clock asserted in full-on without throttling");

    reset_follows_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        inReset |=> !processorResetOutN)
        else $error("processor reset not asserted under platform reset");

    release_sync_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(processorResetOutN) |-> $past(releaseDue) && $past(platformResetInN))
        else $error("processor reset released off the delay count");

    release_delay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        $rose(processorResetOutN) |-> highRun == RUN_CNT_W'(RELEASE_CYCLES))
        else $error("processor reset released at wrong delay");

    early_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (highRun < RUN_CNT_W'(RELEASE_CYCLES)) |-> !processorResetOutN)
        else $error("processor reset released before full delay");

    reset_defaults_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        inReset |=> (cpuState == FULL_ON_ST && stopClockRequestN && releaseCount == '0))
        else $error("platform reset left state out of default");

    sequence exitTaken_s;
        cpuState == STOP_GRANT_ST && pmCtrl.stopGrantExit && platformResetInN;
    endsequence

    sequence fullOnIdle_s;
        cpuState == FULL_ON_ST && stopClockRequestN;
    endsequence

    sequence releaseCounting_s;
        platformResetInN && !processorResetOutN;
    endsequence

    stop_grant_stay_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (cpuState == STOP_GRANT_ST && platformResetInN && !pmCtrl.stopGrantExit) |=> stopGrantHeld_s)
        else $error("stop-grant left without a break event");

    stop_grant_exit_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        exitTaken_s |=> cpuState == FULL_ON_ST)
        else $error("break event did not return to full-on");

    exit_idle_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (exitTaken_s ##0 !pmCtrl.throttleEnable) |=> fullOnIdle_s)
        else $error("stop-clock still asserted after return to full-on");

    level2_refused_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (!running && cpuState == FULL_ON_ST) |=> cpuState == FULL_ON_ST)
        else $error("level-2 read taken during reset or release delay");

    delay_no_stop_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !processorResetOutN |=> stopClockRequestN)
        else $error("stop-clock asserted while processor is in reset");

    count_step_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        releaseCounting_s |=> releaseCount == RELEASE_CNT_W'($past(releaseCount) + 1'b1))
        else $error("release counter skipped a cycle");

    count_tracks_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        releaseCounting_s |-> RUN_CNT_W'(releaseCount) == highRun)
        else $error("release counter not restarted by platform reset");

    released_stays_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        (processorResetOutN && platformResetInN) |=> processorResetOutN)
        else $error("processor reset reasserted without platform reset");

    status_release_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        processorResetOutN |=> pmStatus.resetReleased)
        else $error("release status does not follow processor reset");

    throttle_status_a: assert property (@(posedge sys_clk) disable iff (!resetn)
        !pmCtrl.throttleEnable |=> !pmStatus.throttling)
        else $error("throttling status set while throttling is off");

endmodule

`default_nettype wire

// *** verif/io_hub_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module io_hub_model (
    input wire logic powerGood,
    input wire logic releaseReq,
    output logic platformResetInN
);
    // Platform reset stays asserted until power is stable
    assign platformResetInN = powerGood & releaseReq;
endmodule

`default_nettype wire

// *** verif/hub_reset_and_cpu_stop_control_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module hub_reset_and_cpu_stop_control_tb;
    import hub_pm_pkg::*;
    localparam int REL = 20;
    localparam int PERIOD = THROTTLE_SLOTS * THROTTLE_SLOT_CYCLES;
    logic sys_clk = 1'h0;
    logic resetn = 1'h0;
    logic powerGood = 1'h0;
    logic releaseReq = 1'h1;
    pm_ctrl_t pmCtrl = '0;
    wire platformResetInN;
    logic processorResetOutN;
    logic stopClockRequestN;
    pm_status_t pmStatus;
    int errorCnt = 0;
    int numChecks = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    io_hub_model hub (.powerGood(powerGood), .releaseReq(releaseReq), .platformResetInN(platformResetInN));

    hub_reset_and_cpu_stop_control #(.RELEASE_CYCLES(REL)) uut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .platformResetInN(platformResetInN),
        .pmCtrl(pmCtrl),
        .processorResetOutN(processorResetOutN),
        .stopClockRequestN(stopClockRequestN),
        .pmStatus(pmStatus)
    );

    task automatic fail(input string m);
        errorCnt++;
        numChecks++;
        $display("ERROR %0t: %s", $time, m);
    endtask

    task automatic pass();
        numChecks++;
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Counts edges until the processor reset output is released
    task automatic count_release(output int n);
        n = 0;
        do begin
            step(1);
            n++;
        end while (processorResetOutN !== 1'h1 && n < 100);
    endtask

    task automatic count_low(input int skip, input int len, output int lows);
        step(skip);
        lows = 0;
        repeat (len) begin
            step(1);
            if (stopClockRequestN !== 1'h1) lows++;
        end
    endtask

    task automatic t_release();
        int n;
        step(3);
        if (processorResetOutN !== 1'h0) fail("processor reset not held"); else pass();
        powerGood = 1'h1;
        count_release(n);
        if (n != REL) fail("release delay wrong"); else pass();
        if (pmStatus.resetReleased !== 1'h0) fail("release status early"); else pass();
        step(1);
        if (pmStatus.resetReleased !== 1'h1) fail("release status missing"); else pass();
    endtask

    task automatic t_restart();
        int n;
        releaseReq = 1'h0;
        step(1);
        if (processorResetOutN !== 1'h0) fail("reset not reasserted"); else pass();
        releaseReq = 1'h1;
        step(REL - 5);
        releaseReq = 1'h0;
        step(1);
        releaseReq = 1'h1;
        count_release(n);
        if (n != REL) fail("delay not restarted"); else pass();
    endtask

    task automatic t_stop_grant();
        int lows;
        pmCtrl.level2Read = 1'h1;
        step(1);
        pmCtrl.level2Read = 1'h0;
        if (stopClockRequestN !== 1'h0) fail("no stop-grant entry"); else pass();
        step(1);
        if (pmStatus.inStopGrant !== 1'h1) fail("status not in stop-grant"); else pass();
        pmCtrl.stopGrantExit = 1'h1;
        step(1);
        pmCtrl.stopGrantExit = 1'h0;
        if (stopClockRequestN !== 1'h1) fail("stop-grant not left"); else pass();
        count_low(0, 40, lows);
        if (lows != 0) fail("stop-clock in full-on"); else pass();
    endtask

    task automatic t_throttle();
        int lows;
        for (int d = 0; d < THROTTLE_SLOTS; d++) begin
            pmCtrl.throttleDuty = DUTY_W'(d);
            pmCtrl.throttleEnable = 1'h1;
            step(2);
            if (stopClockRequestN !== (d == 0) || pmStatus.throttling !== (d > 0)) fail("throttle start wrong"); else pass();
            count_low(6, 2 * PERIOD, lows);
            if (lows != 2 * d * THROTTLE_SLOT_CYCLES) fail("duty cycle wrong"); else pass();
            pmCtrl.throttleEnable = 1'h0;
            step(2);
        end
        count_low(2, 2 * PERIOD, lows);
        if (lows != 0) fail("throttling while disabled"); else pass();
    endtask

    task automatic t_platform_reset();
        int n;
        int lows;
        pmCtrl.level2Read = 1'h1;
        step(1);
        pmCtrl.level2Read = 1'h0;
        step(4);
        releaseReq = 1'h0;
        step(2);
        if (processorResetOutN !== 1'h0 || stopClockRequestN !== 1'h1) fail("outputs not reset"); else pass();
        if (pmStatus !== '0) fail("status not reset"); else pass();
        releaseReq = 1'h1;
        // A level-2 read during the release delay must be ignored
        pmCtrl.level2Read = 1'h1;
        step(1);
        pmCtrl.level2Read = 1'h0;
        count_release(n);
        if (n != REL - 1) fail("release delay after reset wrong"); else pass();
        count_low(1, 40, lows);
        if (lows != 0) fail("stop-grant survived reset"); else pass();
    endtask

    // Cuts a hang short
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            fail("timeout");
            complete_run();
        end
    end

    initial begin
        step(12);
        resetn = 1'h1;
        t_release();
        t_restart();
        t_stop_grant();
        t_throttle();
        t_platform_reset();
        complete_run();
    end
endmodule

`default_nettype wire
